//--- hdl/i2cmt_master_tx.sv
// i2cmt_master_tx: i2c master-transmit state handling with set/clear control ports.
// assumes open-drain pads resolved outside; scl/sda arrive asynchronous to both clocks;
// clk_link_i runs free.

module i2cmt_master_tx
   import i2cmt_pkg::*;
#(
   parameter int QTR_CYC = SCL_QTR_CYC
) (
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic        clk_link_i,
   input  wire i2cmt_ctrl_t ctrl_flag_setter_i,
   input  wire logic        ctrl_flag_setter_we_i,
   input  wire i2cmt_ctrl_t ctrl_flag_clearer_i,
   input  wire logic        ctrl_flag_clearer_we_i,
   input  wire logic [6:0]  own_addr_i,
   input  wire logic [7:0]  shift_byte_i,
   input  wire logic        shift_byte_valid_i,
   output logic             shift_byte_ready_o,
   output i2cmt_ctrl_t      ctrl_flags_o,
   output logic [7:0]       bus_phase_register_o,
   output logic             master_receive_mode_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o
);

   if (QTR_CYC < 1 || QTR_CYC > 65535) begin : g_bad_qtr
      $error("QTR_CYC out of range");
   end

   // ------------------------------------------------------------------
   // system domain: control flags
   // ------------------------------------------------------------------
   i2cmt_ctrl_t     ctrl_q, ctrl_d;
   logic [4:0]      code_q, code_nx;
   logic            ev_tg_q;
   logic            master_act_q, outst_q, want_q, mrx_q;
   i2cmt_cmd_kind_t want_kind_q, kind_n;
   logic            want_n, sw_ack, launch, ev_new, ev_s1, ev_s2, ev_s3;
   i2cmt_evt_t      ev_q;
   i2cmt_cmd_t      cmd_q;
   logic            cmd_tg_q;
   logic [7:0]      fifo_mem [BUF_DEPTH];
   logic            wr_ptr_q, rd_ptr_q;
   logic [1:0]      cnt_q, cnt_d;
   logic [7:0]      code_full;

   assign code_full = {code_q, 3'b000};

   always_comb begin
      ctrl_d = ctrl_q;
      if (ctrl_flag_setter_we_i) ctrl_d = ctrl_d | ctrl_flag_setter_i;
      if (ctrl_flag_clearer_we_i) ctrl_d = ctrl_d & ~ctrl_flag_clearer_i;
      if (ev_new && ev_q.stop_seen) ctrl_d.halt_request_bit = 1'b0;
      if (ev_new && ev_q.raise) ctrl_d.event_flag = 1'b1;
   end

   assign sw_ack = ctrl_q.event_flag && !ctrl_d.event_flag && master_act_q;

   // next master action chosen from the latched phase code on flag clear
   always_comb begin
      want_n = 1'b0;
      kind_n = CMD_BYTE;
      if (sw_ack) begin
         unique case (code_full)
            PH_START, PH_RSTART: begin
               want_n = 1'b1;
            end
            PH_AW_ACK, PH_AW_NACK, PH_D_ACK, PH_D_NACK, PH_AR_ACK, PH_AR_NACK: begin
               want_n = 1'b1;
               if (ctrl_d.begin_request_bit && ctrl_d.halt_request_bit) begin
                  kind_n = CMD_STOP_START;
               end else if (ctrl_d.halt_request_bit) begin
                  kind_n = CMD_STOP;
               end else if (ctrl_d.begin_request_bit) begin
                  kind_n = CMD_START;
               end else begin
                  kind_n = CMD_BYTE;
               end
            end
            default: begin
               want_n = 1'b0;
            end
         endcase
      end else if (!master_act_q && !outst_q && !want_q && ctrl_q.en
                   && ctrl_q.begin_request_bit && !ctrl_q.event_flag) begin
         want_n = 1'b1;
         kind_n = CMD_START;
      end
   end

   assign launch = want_q && !outst_q && (want_kind_q != CMD_BYTE || cnt_q != 2'h0);

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         want_q      <= 1'b0;
         want_kind_q <= CMD_START;
         outst_q     <= 1'b0;
         cmd_q       <= '0;
         cmd_tg_q    <= 1'b0;
      end else begin
         if (want_n) begin
            want_q      <= 1'b1;
            want_kind_q <= kind_n;
         end else if (launch) begin
            want_q <= 1'b0;
         end
         if (launch) begin
            outst_q       <= 1'b1;
            cmd_q.kind    <= want_kind_q;
            cmd_q.data    <= fifo_mem[rd_ptr_q];
            cmd_q.ack_en  <= ctrl_q.acknowledge_enable;
            cmd_q.own_addr <= own_addr_i;
            cmd_tg_q      <= ~cmd_tg_q;
         end else if (ev_new) begin
            outst_q <= 1'b0;
         end
      end
   end

   // code and flag move on the same edge, so software never reads a stale code
   always_comb begin
      code_nx = code_q;
      if (ev_new && ev_q.raise && !ctrl_q.event_flag) code_nx = ev_q.code;
      if (ev_new && !ev_q.raise) code_nx = PH_IDLE[7:3];
   end

   // phase code, master ownership and receive-mode flag
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         code_q       <= PH_IDLE[7:3];
         master_act_q <= 1'b0;
         mrx_q        <= 1'b0;
      end else begin
         code_q <= code_nx;
         if (ev_new) begin
            master_act_q <= ev_q.raise && ev_q.code <= PH_AR_NACK[7:3]
                            && ev_q.code != PH_ARB_LOST[7:3];
            if (ev_q.raise && ev_q.code == PH_START[7:3]) mrx_q <= 1'b0;
         end
         if (launch && want_kind_q == CMD_BYTE
             && (code_full == PH_START || code_full == PH_RSTART)) begin
            mrx_q <= fifo_mem[rd_ptr_q][0];
         end
      end
   end

   // ------------------------------------------------------------------
   // two-entry byte buffer
   // ------------------------------------------------------------------
   logic push, pop;
   assign push = shift_byte_valid_i && shift_byte_ready_o;
   assign pop  = launch && want_kind_q == CMD_BYTE;

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) cnt_d = cnt_q + 2'h1;
      if (pop && !push) cnt_d = cnt_q - 2'h1;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr_q           <= 1'b0;
         rd_ptr_q           <= 1'b0;
         cnt_q              <= 2'h0;
         shift_byte_ready_o <= 1'b0;
      end else begin
         if (push) wr_ptr_q <= ~wr_ptr_q;
         if (pop) rd_ptr_q <= ~rd_ptr_q;
         cnt_q              <= cnt_d;
         shift_byte_ready_o <= cnt_d != BUF_FULL;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (push) fifo_mem[wr_ptr_q] <= shift_byte_i;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_flags_o          <= CTRL_RST;
         bus_phase_register_o  <= PH_IDLE;
         master_receive_mode_o <= 1'b0;
         ev_s1                 <= 1'b0;
         ev_s2                 <= 1'b0;
         ev_s3                 <= 1'b0;
      end else begin
         ctrl_flags_o          <= ctrl_d;
         bus_phase_register_o  <= {code_nx, 3'b000};
         master_receive_mode_o <= mrx_q;
         ev_s1                 <= ev_tg_q;
         ev_s2                 <= ev_s1;
         ev_s3                 <= ev_s2;
      end
   end

   assign ev_new = ev_s2 ^ ev_s3;

   // ------------------------------------------------------------------
   // link domain: bit engine
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      L_IDLE = 4'h0, L_FREE = 4'h1, L_RS = 4'h2, L_S0 = 4'h3, L_S1 = 4'h4,
      L_S2 = 4'h5, L_HOLD = 4'h6, L_BIT = 4'h7, L_P0 = 4'h8, L_P1 = 4'h9,
      L_P2 = 4'hA
   } i2cmt_lstate_t;

   i2cmt_lstate_t st_q;
   logic          scl_s1, scl_s2, sda_s1, sda_s2, sda_p, scl_p, busy_q;
   logic          cm_s1, cm_s2, cm_s3, cmd_new, tick;
   logic [15:0]   div_q;
   logic [1:0]    ph_q;
   logic [3:0]    bit_q;
   logic [7:0]    shr_q, rx_q;
   logic          lost_q, addr_q, nack_q, rep_q, stop_q, match;
   i2cmt_cmd_t    lcmd_q;

   assign cmd_new = cm_s2 ^ cm_s3;
   assign tick    = div_q == 16'h0;
   assign match   = lcmd_q.ack_en && (rx_q[7:1] == lcmd_q.own_addr || rx_q == GC_ADDR);
   assign scl_o   = 1'b0;
   assign sda_o   = 1'b0;

   always_ff @(posedge clk_link_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p} <= 6'h3F;
         {cm_s1, cm_s2, cm_s3} <= 3'h0;
         busy_q <= 1'b0;
         div_q  <= 16'h0;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_p  <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_p  <= sda_s2;
         cm_s1  <= cmd_tg_q;
         cm_s2  <= cm_s1;
         cm_s3  <= cm_s2;
         if (scl_s2 && scl_p && sda_p && !sda_s2) busy_q <= 1'b1;
         if (scl_s2 && scl_p && !sda_p && sda_s2) busy_q <= 1'b0;
         div_q <= tick ? 16'(QTR_CYC - 1) : div_q - 16'h1;
      end
   end

   always_ff @(posedge clk_link_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= L_IDLE;
         {scl_oe_o, sda_oe_o, lost_q, addr_q, nack_q, rep_q, stop_q, ev_tg_q} <= 8'h0;
         {ph_q, bit_q, shr_q, rx_q} <= 22'h0;
         lcmd_q <= '0;
         ev_q   <= '0;
      end else begin
         unique case (st_q)
            L_IDLE, L_HOLD: begin
               if (cmd_new) begin
                  lcmd_q <= cmd_q;
                  stop_q <= 1'b0;
                  if (st_q == L_IDLE) begin
                     if (cmd_q.kind == CMD_START || cmd_q.kind == CMD_STOP_START) begin
                        st_q <= L_FREE;
                     end else begin
                        ev_q    <= '0;
                        ev_tg_q <= ~ev_tg_q;
                     end
                  end else if (cmd_q.kind == CMD_BYTE) begin
                     {shr_q, bit_q, ph_q, lost_q} <= {cmd_q.data, 7'h0};
                     st_q <= L_BIT;
                  end else if (cmd_q.kind == CMD_START) begin
                     st_q <= L_RS;
                  end else begin
                     st_q <= L_P0;
                  end
               end
            end
            L_FREE: begin
               rep_q <= 1'b0;
               if (tick && !busy_q && scl_s2 && sda_s2) begin
                  sda_oe_o <= 1'b1;
                  st_q     <= L_S1;
               end
            end
            L_RS: begin
               rep_q <= 1'b1;
               if (tick) begin
                  {scl_oe_o, sda_oe_o} <= 2'b00;
                  st_q <= L_S0;
               end
            end
            L_S0: begin
               if (tick && scl_s2) begin
                  sda_oe_o <= 1'b1;
                  st_q     <= L_S1;
               end
            end
            L_S1: begin
               if (tick) begin
                  scl_oe_o <= 1'b1;
                  st_q     <= L_S2;
               end
            end
            L_S2: begin
               if (tick) begin
                  ev_q    <= {2'b10, (rep_q ? PH_RSTART[7:3] : PH_START[7:3])};
                  ev_q.stop_seen <= stop_q;
                  ev_tg_q <= ~ev_tg_q;
                  addr_q  <= 1'b1;
                  st_q    <= L_HOLD;
               end
            end
            L_BIT: begin
               if (tick && (ph_q != 2'h2 || scl_s2)) ph_q <= ph_q + 2'h1;
               if (tick && ph_q == 2'h0) begin
                  sda_oe_o <= bit_q < 4'(LAST_BIT) ? (!shr_q[7] && !lost_q)
                                                   : (lost_q && addr_q && match);
               end
               if (tick && ph_q == 2'h1) scl_oe_o <= 1'b0;
               if (tick && ph_q == 2'h2 && scl_s2) begin
                  if (bit_q < 4'(LAST_BIT)) rx_q <= {rx_q[6:0], sda_s2};
                  else nack_q <= sda_s2;
                  if (bit_q < 4'(LAST_BIT) && shr_q[7] && !sda_s2) begin
                     lost_q   <= 1'b1;
                     sda_oe_o <= 1'b0;
                  end
               end
               if (tick && ph_q == 2'h3) begin
                  shr_q    <= {shr_q[6:0], 1'b0};
                  scl_oe_o <= 1'b1;
                  bit_q    <= bit_q + 4'h1;
                  if (bit_q == 4'(LAST_BIT)) begin
                     ev_tg_q  <= ~ev_tg_q;
                     addr_q   <= 1'b0;
                     sda_oe_o <= 1'b0;
                     st_q     <= L_HOLD;
                     if (lost_q) begin
                        scl_oe_o <= 1'b0;
                        st_q     <= L_IDLE;
                        ev_q     <= {2'b10, PH_ARB_LOST[7:3]};
                        if (addr_q && match) begin
                           ev_q.code <= rx_q == GC_ADDR ? PH_SL_GC[7:3]
                                      : (rx_q[0] ? PH_SL_RD[7:3] : PH_SL_WR[7:3]);
                        end
                     end else if (addr_q) begin
                        ev_q <= {2'b10, (lcmd_q.data[0] ? (nack_q ? PH_AR_NACK[7:3]
                                : PH_AR_ACK[7:3]) : (nack_q ? PH_AW_NACK[7:3]
                                : PH_AW_ACK[7:3]))};
                     end else begin
                        ev_q <= {2'b10, (nack_q ? PH_D_NACK[7:3] : PH_D_ACK[7:3])};
                     end
                  end
               end
            end
            L_P0: begin
               if (tick) begin
                  sda_oe_o <= 1'b1;
                  st_q     <= L_P1;
               end
            end
            L_P1: begin
               if (tick) begin
                  scl_oe_o <= 1'b0;
                  st_q     <= L_P2;
               end
            end
            L_P2: begin
               if (tick && scl_s2) begin
                  sda_oe_o <= 1'b0;
                  stop_q   <= 1'b1;
                  if (lcmd_q.kind == CMD_STOP_START) begin
                     st_q <= L_FREE;
                  end else begin
                     ev_q    <= {2'b01, 5'h0};
                     ev_tg_q <= ~ev_tg_q;
                     st_q    <= L_IDLE;
                  end
               end
            end
            default: begin
               st_q <= L_IDLE;
            end
         endcase
      end
   end

endmodule : i2cmt_master_tx

//--- hdl/i2cmt_pkg.sv
// i2cmt_pkg: constants and carrier types of the i2c master-transmit state block.
// assumes one system clock and one link clock, both free running.
package i2cmt_pkg;

   // ------------------------------------------------------------------
   // bus phase codes (full byte; the low three bits are always zero)
   // ------------------------------------------------------------------
   localparam logic [7:0] PH_IDLE     = 8'hF8;
   localparam logic [7:0] PH_START    = 8'h08;
   localparam logic [7:0] PH_RSTART   = 8'h10;
   localparam logic [7:0] PH_AW_ACK   = 8'h18;
   localparam logic [7:0] PH_AW_NACK  = 8'h20;
   localparam logic [7:0] PH_D_ACK    = 8'h28;
   localparam logic [7:0] PH_D_NACK   = 8'h30;
   localparam logic [7:0] PH_ARB_LOST = 8'h38;
   localparam logic [7:0] PH_AR_ACK   = 8'h40;
   localparam logic [7:0] PH_AR_NACK  = 8'h48;
   localparam logic [7:0] PH_SL_WR    = 8'h68;
   localparam logic [7:0] PH_SL_GC    = 8'h78;
   localparam logic [7:0] PH_SL_RD    = 8'hB0;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int SCL_QTR_NS     = 2500;   // quarter of a 100 kHz scl period
   localparam int LINK_PERIOD_PS = 12000;
   localparam int SCL_QTR_CYC    = (SCL_QTR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;

   // ------------------------------------------------------------------
   // buffer and field sizes
   // ------------------------------------------------------------------
   localparam int          BUF_DEPTH  = 2;
   localparam int          LAST_BIT   = 8;   // index of the acknowledge bit
   localparam logic [1:0]  BUF_FULL   = 2'h2;
   localparam logic [7:0]  GC_ADDR    = 8'h00;

   typedef struct packed {
      logic en;                  // enables a start from idle; a transfer under way ignores it
      logic begin_request_bit;
      logic halt_request_bit;
      logic event_flag;
      logic acknowledge_enable;
   } i2cmt_ctrl_t;

   localparam i2cmt_ctrl_t CTRL_RST = '{default: 1'b0};

   typedef enum logic [1:0] {
      CMD_START      = 2'b00,
      CMD_BYTE       = 2'b01,
      CMD_STOP       = 2'b10,
      CMD_STOP_START = 2'b11
   } i2cmt_cmd_kind_t;

   typedef struct packed {
      i2cmt_cmd_kind_t kind;
      logic [7:0]      data;
      logic            ack_en;
      logic [6:0]      own_addr;
   } i2cmt_cmd_t;

   typedef struct packed {
      logic       raise;         // sets the event flag
      logic       stop_seen;     // a stop went out before this event
      logic [4:0] code;
   } i2cmt_evt_t;

endpackage : i2cmt_pkg

//--- bench/i2cmt_slave_model.sv
// i2cmt_slave_model: behavioural slave plus rival master on the open-drain lines.
// assumes pull-ups on both lines; the block under test drives only its enables.
module i2cmt_slave_model (
   input  wire logic  scl_oe_i,
   input  wire logic  sda_oe_i,
   input  wire logic  nack_i,
   input  wire logic  rival_i,
   output logic       scl_o,
   output logic       sda_o,
   output logic [7:0] byte_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ack_q;
   int   k;
   // ------------------------------------------------------------------
   // wired-and lines; k counts the bit slot of the current byte
   // ------------------------------------------------------------------
   initial begin
      ack_q = 1'b0;
      k = 0;
      byte_o = 8'h00;
   end
   assign scl_o = !scl_oe_i;
   // the rival pulls data low through the byte bits, so a 1 from the master loses
   assign sda_o = !(sda_oe_i || ack_q || (rival_i && k >= 1 && k <= 8));
   always @(negedge sda_o) begin
      if (scl_o === 1'b1) begin
         k = 0;
      end
   end
   always @(posedge scl_o) begin
      if (k >= 1 && k <= 8) begin
         byte_o = {byte_o[6:0], sda_o};
      end
   end
   // lines change only while scl is low
   always @(negedge scl_o) begin
      k = (k >= 9) ? 1 : k + 1;
      ack_q = (k == 9) && !nack_i;
   end
endmodule : i2cmt_slave_model

//--- bench/i2cmt_master_tx_chk.sv
// i2cmt_master_tx_chk: port assertions for the master-transmit state block.
// assumes it is bound into i2cmt_master_tx and sees only its ports.
module i2cmt_master_tx_chk
   import i2cmt_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        nrst_i,
   input wire i2cmt_ctrl_t ctrl_flag_setter_i,
   input wire logic        ctrl_flag_setter_we_i,
   input wire i2cmt_ctrl_t ctrl_flag_clearer_i,
   input wire logic        ctrl_flag_clearer_we_i,
   input wire i2cmt_ctrl_t ctrl_flags_o,
   input wire logic [7:0]  bus_phase_register_o,
   input wire logic        scl_oe_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // ------------------------------------------------------------------
   // sequences and properties
   // ------------------------------------------------------------------
   sequence s_hw_raise;
      $rose(ctrl_flags_o.event_flag) && !$past(ctrl_flag_setter_we_i);
   endsequence
   sequence s_held;
      ctrl_flags_o.event_flag [*4];
   endsequence
   property p_code_legal;
      s_hw_raise |-> bus_phase_register_o inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28,
         8'h30, 8'h38, 8'h40, 8'h48, 8'h68, 8'h78, 8'hB0};
   endproperty
   property p_slave_ack;
      (s_hw_raise ##0 (bus_phase_register_o inside {8'h68, 8'h78, 8'hB0}))
         |-> ctrl_flags_o.acknowledge_enable;
   endproperty
   property p_low_zero;
      bus_phase_register_o[2:0] == 3'h0;
   endproperty
   property p_hold;
      ctrl_flags_o.event_flag && $past(ctrl_flags_o.event_flag) |-> $stable(bus_phase_register_o);
   endproperty
   property p_stretch;
      (s_held ##0 (bus_phase_register_o inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30}))
         |-> scl_oe_o;
   endproperty
   property p_set;
      ctrl_flag_setter_we_i && !ctrl_flag_clearer_we_i
         |=> (ctrl_flags_o & $past(ctrl_flag_setter_i)) == $past(ctrl_flag_setter_i);
   endproperty
   property p_clr;
      ctrl_flag_clearer_we_i |=> (ctrl_flags_o & $past(ctrl_flag_clearer_i) & 5'h1D) == 5'h00;
   endproperty
   property p_halt_done;
      $fell(ctrl_flags_o.halt_request_bit) && !$past(ctrl_flag_clearer_we_i)
         |-> bus_phase_register_o == 8'hF8
             || (ctrl_flags_o.event_flag && bus_phase_register_o == 8'h08);
   endproperty
   a_code_legal: assert property (p_code_legal) else $error("illegal phase code");
   a_slave_ack: assert property (p_slave_ack) else $error("slave code without ack");
   a_low_zero: assert property (p_low_zero) else $error("phase low bits set");
   a_hold: assert property (p_hold) else $error("phase moved while flag set");
   a_stretch: assert property (p_stretch) else $error("scl not held low");
   a_set: assert property (p_set) else $error("set port missed a bit");
   a_clr: assert property (p_clr) else $error("clear port missed a bit");
   a_halt_done: assert property (p_halt_done) else $error("halt cleared early");
endmodule : i2cmt_master_tx_chk

bind i2cmt_master_tx i2cmt_master_tx_chk u_chk (
   .clk_sys_i              (clk_sys_i),
   .nrst_i                 (nrst_i),
   .ctrl_flag_setter_i     (ctrl_flag_setter_i),
   .ctrl_flag_setter_we_i  (ctrl_flag_setter_we_i),
   .ctrl_flag_clearer_i    (ctrl_flag_clearer_i),
   .ctrl_flag_clearer_we_i (ctrl_flag_clearer_we_i),
   .ctrl_flags_o           (ctrl_flags_o),
   .bus_phase_register_o   (bus_phase_register_o),
   .scl_oe_o               (scl_oe_o)
);

//--- bench/i2cmt_master_tx_bench.sv
// i2cmt_master_tx_bench: directed self-checking bench for the master-transmit block.
// assumes the slave model on the pads and a free-running 12 ns link clock.
module i2cmt_master_tx_bench
   import i2cmt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] F_EN = 5'h10, F_BEG = 5'h08, F_HALT = 5'h04;
   localparam logic [4:0] F_EVT = 5'h02, F_ACK = 5'h01;
   logic        clk_sys_i = 1'b0;
   logic        clk_link_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        set_we = 1'b0;
   logic        clr_we = 1'b0;
   logic        push_v = 1'b0;
   logic        nack = 1'b0;
   logic        rival = 1'b0;
   logic [4:0]  set_v = 5'h00;
   logic [4:0]  clr_v = 5'h00;
   logic [7:0]  push_b = 8'h00;
   wire logic   rdy, rx_mode, scl, sda, scl_oe, sda_oe;
   wire logic [7:0] phase, seen;
   i2cmt_ctrl_t flags;
   int          bad_count = 0;
   int          compares = 0;
   int          cyc = 0;

   always #5 clk_sys_i = ~clk_sys_i;
   always #6 clk_link_i = ~clk_link_i;

   i2cmt_master_tx #(.QTR_CYC(4)) uut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_link_i(clk_link_i),
      .ctrl_flag_setter_i(i2cmt_ctrl_t'(set_v)), .ctrl_flag_setter_we_i(set_we),
      .ctrl_flag_clearer_i(i2cmt_ctrl_t'(clr_v)), .ctrl_flag_clearer_we_i(clr_we),
      .own_addr_i(7'h2A), .shift_byte_i(push_b), .shift_byte_valid_i(push_v),
      .shift_byte_ready_o(rdy), .ctrl_flags_o(flags), .bus_phase_register_o(phase),
      .master_receive_mode_o(rx_mode), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
   i2cmt_slave_model u_far (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .nack_i(nack),
      .rival_i(rival), .scl_o(scl), .sda_o(sda), .byte_o(seen));

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic set, input logic [4:0] v);
      @(posedge clk_sys_i);
      #1;
      set_we = set;
      clr_we = !set;
      set_v = v;
      clr_v = v;
      @(posedge clk_sys_i);
      #1;
      set_we = 1'b0;
      clr_we = 1'b0;
   endtask : wr
   task automatic push(input logic [7:0] b);
      @(posedge clk_sys_i);
      #1;
      push_v = 1'b1;
      push_b = b;
      do @(posedge clk_sys_i); while (rdy !== 1'b1);
      #1;
      push_v = 1'b0;
   endtask : push
   task automatic wait_evt(input logic [7:0] code);
      while (flags.event_flag !== 1'b1) begin
         @(posedge clk_sys_i);
         #1;
      end
      chk(phase, code);
   endtask : wait_evt

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_ctrl;
      chk(flags, 8'h00);
      chk(phase, PH_IDLE);
      wr(1, F_EN | F_ACK | F_HALT);
      chk(flags, F_EN | F_ACK | F_HALT);
      wr(0, F_HALT);
      chk(flags, F_EN | F_ACK);
   endtask : t_ctrl
   task automatic t_fill;
      push(8'hA0);
      push(8'h55);
      chk(rdy, 1'b0);
   endtask : t_fill
   task automatic t_addr;
      wr(1, F_BEG);
      wait_evt(PH_START);
      repeat (20) @(posedge clk_sys_i);
      chk(scl_oe, 1'b1);
      wr(0, F_BEG | F_EVT);
      wait_evt(PH_AW_ACK);
      chk(seen, 8'hA0);
      chk(rdy, 1'b1);
   endtask : t_addr
   task automatic t_data;
      wr(0, F_EVT);
      wait_evt(PH_D_ACK);
      chk(seen, 8'h55);
      nack = 1'b1;
      push(8'h3C);
      wr(0, F_EVT);
      wait_evt(PH_D_NACK);
      chk(seen, 8'h3C);
      nack = 1'b0;
   endtask : t_data
   task automatic t_read;
      wr(1, F_BEG);
      wr(0, F_EVT);
      wait_evt(PH_RSTART);
      push(8'hA1);
      wr(0, F_BEG | F_EVT);
      wait_evt(PH_AR_ACK);
      chk(rx_mode, 1'b1);
   endtask : t_read
   task automatic t_stop;
      wr(1, F_HALT);
      wr(0, F_EVT);
      while (flags.halt_request_bit !== 1'b0) @(posedge clk_sys_i);
      repeat (4) @(posedge clk_sys_i);
      chk(phase, PH_IDLE);
      chk(flags, F_EN | F_ACK);
      chk(scl_oe | sda_oe, 1'b0);
   endtask : t_stop
   task automatic t_stop_start;
      wr(1, F_BEG);
      wait_evt(PH_START);
      push(8'hA0);
      wr(0, F_BEG | F_EVT);
      wait_evt(PH_AW_ACK);
      wr(1, F_BEG | F_HALT);
      wr(0, F_EVT);
      wait_evt(PH_START);
      chk(flags.halt_request_bit, 1'b0);
   endtask : t_stop_start
   task automatic t_arb;
      wr(0, F_ACK | F_BEG);
      rival = 1'b1;
      push(8'hA0);
      wr(0, F_EVT);
      wait_evt(PH_ARB_LOST);
      rival = 1'b0;
      wr(0, F_EVT);
      repeat (200) @(posedge clk_sys_i);
      chk(scl_oe | sda_oe, 1'b0);
   endtask : t_arb

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys_i);
      #1;
      nrst_i = 1'b1;
      repeat (2) @(posedge clk_sys_i);
      t_ctrl();
      t_fill();
      t_addr();
      t_data();
      t_read();
      t_stop();
      t_stop_start();
      t_arb();
      give_verdict();
   end
endmodule : i2cmt_master_tx_bench
